// ===== core/rx_fifo_status_pkg.sv
// Types and constants for the receive FIFO and status interface.
// Assumes every user of these types runs on the receive MAC clock.
package rx_fifo_status_pkg;

    // ----------------------------------------
    // Status word layout
    // ----------------------------------------
    localparam int ST_COUNT_MSB = 15;
    localparam int ST_VLAN = 16;
    localparam int ST_PAUSE = 17;
    localparam int ST_CTRL = 18;
    localparam int ST_BAD_OPCODE = 19;
    localparam int ST_DRIBBLE = 20;
    localparam int ST_BCAST = 21;
    localparam int ST_MCAST = 22;
    localparam int ST_RX_OK = 23;
    localparam int ST_LEN_ERR = 24;
    localparam int ST_CRC_ERR = 25;
    localparam int ST_IGNORED = 26;
    localparam int ST_CARRIER = 27;
    localparam int ST_UNUSED = 28;
    localparam int ST_IPG_VIOL = 29;
    localparam int ST_SHORT = 30;
    localparam int ST_LONG = 31;

    // ----------------------------------------
    // Reset values and byte count constants
    // ----------------------------------------
    localparam logic [31:0] STAT_RESET = 32'h0000_0000;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {OPT_CLASSIC, OPT_SGMII, OPT_GIGABIT} mac_option_t;

    // One received byte from the front end
    typedef struct packed {
        logic sof;
        logic eof;
        logic phy_err;
        logic [7:0] data;
    } rx_beat_t;

    // Frame analysis results, valid with the last beat
    typedef struct packed {
        logic vlan;
        logic pause;
        logic ctrl;
        logic bad_opcode;
        logic dribble;
        logic bcast;
        logic mcast;
        logic len_err;
        logic crc_err;
        logic ipg_viol;
        logic short_frame;
        logic long_frame;
    } rx_frame_info_t;

endpackage

// ===== core/rx_fifo_status.sv
// Receive-side FIFO writer and per-frame status reporter of the MAC.
// Assumes beats and frame info arrive on clk_i, the receive MAC clock;
// collision, carrier and drop request come from pins and are synchronised.
`timescale 1ns/1ps

module rx_fifo_status
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rx_enable_i,
    input wire logic gbit_mode_i,
    input wire logic half_duplex_i,
    input wire rx_fifo_status_pkg::mac_option_t mac_option_i,
    input wire logic col_i,
    input wire logic crs_i,
    input wire logic beat_valid_i,
    input wire rx_fifo_status_pkg::rx_beat_t beat_i,
    input wire rx_fifo_status_pkg::rx_frame_info_t info_i,
    input wire logic rx_fifo_full_i,
    input wire logic eof_drained_i,
    input wire logic drop_req_i,
    output logic rx_write_o,
    output logic [7:0] rx_data_o,
    output logic rx_eof_o,
    output logic rx_error_o,
    output logic rx_fifo_error_o,
    output logic [31:0] rx_stat_o,
    output logic rx_stat_valid_o
);
    import rx_fifo_status_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // clk_i is the receive MAC clock: the PHY clock halved in 10/100 and
    // the PHY clock itself in gigabit; the divider sits in the clock tree.
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end
        else
        begin
            sync1_q <= {drop_req_i, crs_i, col_i};
            sync2_q <= sync1_q;
        end
    end

    logic half_10_100;
    logic col_s;
    logic crs_s;
    logic drop_s;

    // Collision and carrier only matter in half-duplex 10/100 on the
    // classic or SGMII options; everywhere else they are ignored.
    assign half_10_100 = half_duplex_i && !gbit_mode_i && (mac_option_i != OPT_GIGABIT);
    assign col_s = sync2_q[0] && half_10_100;
    assign crs_s = sync2_q[1] && half_10_100;
    assign drop_s = sync2_q[2];

    // ----------------------------------------
    // Frame tracking
    // ----------------------------------------
    logic in_frame_q;
    logic keep_q;
    logic drop_frame_q;
    logic err_acc_q;
    logic col_acc_q;
    logic ovf_q;
    logic eof_sent_q;
    logic carrier_q;
    logic write_q;
    logic eof_q;
    logic [15:0] count_q;

    logic start;
    logic active;
    logic fin;
    logic keep_now;
    logic drop_now;
    logic want;
    logic ovf_set;
    logic ovf_clr;
    logic err_now;
    logic col_now;
    logic frame_err;
    logic [15:0] count_d;

    // A frame may only begin while receive is enabled; the decision to
    // drop it is taken once, at its first byte; keep also clears on overflow.
    assign start = beat_valid_i && beat_i.sof && !in_frame_q && rx_enable_i;
    assign active = start || (beat_valid_i && in_frame_q);
    assign fin = active && beat_i.eof;
    assign drop_now = start ? drop_s : drop_frame_q;
    assign keep_now = start ? (!drop_s && !ovf_q) : keep_q;
    assign want = active && keep_now;
    // A strobe already in flight when full rises is a write into a full FIFO too
    assign ovf_set = (want || write_q) && rx_fifo_full_i;
    assign ovf_clr = eof_drained_i && eof_sent_q;
    assign err_now = beat_i.phy_err || (!start && err_acc_q);
    assign col_now = col_s || (!start && col_acc_q);
    assign frame_err = err_now || info_i.crc_err || info_i.len_err;

    always_comb
    begin
        if (start)
        begin
            count_d = COUNT_ONE;
        end
        else if (count_q == COUNT_MAX)
        begin
            count_d = count_q;
        end
        else
        begin
            count_d = count_q + COUNT_ONE;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            in_frame_q <= 1'b0;
            keep_q <= 1'b0;
            drop_frame_q <= 1'b0;
            err_acc_q <= 1'b0;
            col_acc_q <= 1'b0;
            count_q <= 16'h0000;
        end
        else if (active)
        begin
            in_frame_q <= !beat_i.eof;
            keep_q <= keep_now && !ovf_set;
            drop_frame_q <= drop_now;
            err_acc_q <= err_now;
            col_acc_q <= col_now;
            count_q <= count_d;
        end
    end

    // ----------------------------------------
    // Overflow handling
    // ----------------------------------------
    // A full FIFO is a sizing fault on the far side; once hit, the rest of
    // the packet is thrown away and writing waits for the reader to drain
    // past that packet's end mark, so no partial packet follows it.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ovf_q <= 1'b0;
        end
        else if (ovf_set)
        begin
            ovf_q <= 1'b1;
        end
        else if (ovf_clr)
        begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            eof_sent_q <= 1'b0;
        end
        // Armed by the end mark actually presented, so a mark that meets a full FIFO counts
        else if (eof_q && (ovf_q || ovf_set))
        begin
            eof_sent_q <= 1'b1;
        end
        else if (ovf_clr)
        begin
            eof_sent_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Carrier event between frames
    // ----------------------------------------
    // Set wins over the clear taken when the status word is issued.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            carrier_q <= 1'b0;
        end
        else if (crs_s && !in_frame_q && !active)
        begin
            carrier_q <= 1'b1;
        end
        else if (fin)
        begin
            carrier_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // FIFO write side
    // ----------------------------------------
    logic [7:0] data_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            write_q <= 1'b0;
            data_q <= DATA_RESET;
        end
        else
        begin
            write_q <= want && !rx_fifo_full_i && !ovf_q;
            data_q <= active ? beat_i.data : data_q;
        end
    end

    // ----------------------------------------
    // Frame end and status word
    // ----------------------------------------
    logic error_q;
    logic stat_en_q;
    logic [31:0] stat_q;
    logic [31:0] stat_d;

    always_comb
    begin
        stat_d = STAT_RESET;
        stat_d[ST_COUNT_MSB:0] = count_d;
        stat_d[ST_VLAN] = info_i.vlan;
        stat_d[ST_PAUSE] = info_i.pause;
        stat_d[ST_CTRL] = info_i.ctrl;
        stat_d[ST_BAD_OPCODE] = info_i.bad_opcode;
        stat_d[ST_DRIBBLE] = info_i.dribble;
        stat_d[ST_BCAST] = info_i.bcast;
        stat_d[ST_MCAST] = info_i.mcast;
        stat_d[ST_RX_OK] = !frame_err && !col_now && !drop_now && !info_i.short_frame
            && !info_i.long_frame && keep_now && !ovf_set;
        stat_d[ST_LEN_ERR] = info_i.len_err;
        stat_d[ST_CRC_ERR] = info_i.crc_err;
        stat_d[ST_IGNORED] = drop_now;
        stat_d[ST_CARRIER] = carrier_q;
        stat_d[ST_UNUSED] = 1'b0;
        stat_d[ST_IPG_VIOL] = info_i.ipg_viol;
        stat_d[ST_SHORT] = info_i.short_frame;
        stat_d[ST_LONG] = info_i.long_frame;
    end

    // Dropped frames put nothing into the FIFO, so they get no end mark,
    // only a status word.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            eof_q <= 1'b0;
            error_q <= 1'b0;
            stat_en_q <= 1'b0;
            stat_q <= STAT_RESET;
        end
        else
        begin
            eof_q <= fin && !drop_now;
            error_q <= fin && !drop_now && frame_err;
            stat_en_q <= fin;
            stat_q <= fin ? stat_d : stat_q;
        end
    end

    assign rx_write_o = write_q;
    assign rx_data_o = data_q;
    assign rx_eof_o = eof_q;
    assign rx_error_o = error_q;
    assign rx_fifo_error_o = ovf_q;
    assign rx_stat_o = stat_q;
    assign rx_stat_valid_o = stat_en_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_ovf_blocks_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ovf_q |-> !write_q)
        else $error("write strobe high during overflow");

    chk_ovf_raised: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ovf_set |=> ovf_q && !write_q)
        else $error("overflow not raised on write into full FIFO");

    chk_ovf_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ovf_q && !ovf_clr |=> ovf_q)
        else $error("overflow dropped before end mark drained");

    chk_eof_status_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        eof_q |-> stat_en_q && !stat_q[ST_IGNORED])
        else $error("end mark without matching status");

    chk_error_qualified: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        error_q |-> eof_q && !stat_q[ST_RX_OK])
        else $error("error flag not tied to an errored frame end");

    chk_crc_gives_error: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fin && !drop_now && (info_i.crc_err || info_i.len_err) |=> error_q)
        else $error("check error did not raise frame error");

    chk_drop_no_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        active && drop_now |=> !write_q && !eof_q)
        else $error("dropped frame was written");

    chk_data_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        write_q |-> data_q == $past(beat_i.data) && $past(active))
        else $error("written byte differs from received byte");

    chk_disabled_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rx_enable_i && !in_frame_q |=> !write_q && !eof_q)
        else $error("receive path active while disabled");

    chk_status_unused: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stat_en_q |-> !stat_q[ST_UNUSED] && stat_q[ST_COUNT_MSB:0] != 16'h0000)
        else $error("status word malformed");

endmodule

// ===== sim/rx_fifo_model.sv
// Behavioural receive FIFO with its reader, the far side of the status block.
// Assumes one clock shared with the block; depth is kept small to reach full.
`timescale 1ns/1ps

module rx_fifo_model
#(
    parameter int DEPTH = 4
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic drain_en_i,
    input wire logic write_i,
    input wire logic eof_i,
    output logic full_o = 1'b0,
    output logic eof_drained_o = 1'b0
);
    // Entries hold only the end mark; data is checked by the bench
    logic mark_q[$];

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mark_q.delete();
            eof_drained_o <= 1'b0;
        end
        else
        begin
            // Reader keeps pulling even while writes are stopped
            if (drain_en_i && mark_q.size() > 0)
            begin
                eof_drained_o <= mark_q.pop_front();
            end
            else
            begin
                eof_drained_o <= 1'b0;
            end
            // A full FIFO loses the byte; an end mark still passes, even with its last byte
            if ((write_i && mark_q.size() < DEPTH) || eof_i)
            begin
                mark_q.push_back(eof_i);
            end
        end
        full_o <= (mark_q.size() >= DEPTH);
    end
endmodule

// ===== sim/rx_fifo_status_bench.sv
// Self-checking bench for the receive FIFO writer and status reporter.
// Assumes one 20 MHz clock; the FIFO model sits on the far side.
`timescale 1ns/1ps

module rx_fifo_status_bench;
    import rx_fifo_status_pkg::*;
    localparam int DEPTH = 4;
    logic clk_i = 1'b0, rst_n_i = 1'b0, rx_enable_i = 1'b1, gbit_mode_i = 1'b0, half_duplex_i = 1'b1;
    mac_option_t mac_option_i = OPT_CLASSIC;
    logic col_i = 1'b0, crs_i = 1'b0, beat_valid_i = 1'b0, drop_req_i = 1'b0, drain_en = 1'b1;
    rx_beat_t beat_i = '0;
    rx_frame_info_t info_i = '0;
    logic rx_fifo_full_i, eof_drained_i, rx_write_o, rx_eof_o, rx_error_o, rx_fifo_error_o, rx_stat_valid_o;
    logic [7:0] rx_data_o;
    logic [31:0] rx_stat_o, stat_q;
    logic err_q;
    logic [7:0] wq[$];
    int mismatches = 0, compares = 0, stat_n = 0, eof_n = 0, wr_bad = 0;
    int sbit[12] = '{ST_VLAN, ST_PAUSE, ST_CTRL, ST_BAD_OPCODE, ST_DRIBBLE, ST_BCAST, ST_MCAST,
                     ST_LEN_ERR, ST_CRC_ERR, ST_IPG_VIOL, ST_SHORT, ST_LONG};

    always #25 clk_i = ~clk_i;

    rx_fifo_status rx_fifo_status_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_enable_i(rx_enable_i),
        .gbit_mode_i(gbit_mode_i), .half_duplex_i(half_duplex_i), .mac_option_i(mac_option_i),
        .col_i(col_i), .crs_i(crs_i), .beat_valid_i(beat_valid_i), .beat_i(beat_i), .info_i(info_i),
        .rx_fifo_full_i(rx_fifo_full_i), .eof_drained_i(eof_drained_i), .drop_req_i(drop_req_i),
        .rx_write_o(rx_write_o), .rx_data_o(rx_data_o), .rx_eof_o(rx_eof_o), .rx_error_o(rx_error_o),
        .rx_fifo_error_o(rx_fifo_error_o), .rx_stat_o(rx_stat_o), .rx_stat_valid_o(rx_stat_valid_o));

    rx_fifo_model #(.DEPTH(DEPTH)) rx_fifo_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .drain_en_i(drain_en), .write_i(rx_write_o), .eof_i(rx_eof_o), .full_o(rx_fifo_full_i),
        .eof_drained_o(eof_drained_i));

    // ----------------------------------------
    // Output monitor
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (rx_write_o === 1'b1)
            wq.push_back(rx_data_o);
        // A write while overflow stands, or an error flag without end mark
        if ((rx_write_o & rx_fifo_error_o) !== 1'b0 || (rx_error_o & ~rx_eof_o) !== 1'b0)
            wr_bad++;
        if (rx_eof_o === 1'b1)
        begin
            eof_n++;
            err_q = rx_error_o;
        end
        if (rx_stat_valid_o === 1'b1)
        begin
            stat_n++;
            stat_q = rx_stat_o;
        end
    end

    // ----------------------------------------
    // Compare and access tasks
    // ----------------------------------------
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_flag(input string name, input logic exp, input logic got);
        check_word(name, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic send(input int len, input logic perr, input rx_frame_info_t info);
        for (int i = 0; i < len; i++)
        begin
            @(posedge clk_i);
            beat_valid_i <= 1'b1;
            beat_i <= '{sof: (i == 0), eof: (i == len - 1), phy_err: perr, data: 8'(8'h30 + i)};
            info_i <= (i == len - 1) ? info : '0;
        end
        @(posedge clk_i);
        beat_valid_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // One frame, then status, end mark, error flag and stored bytes
    task automatic run(input int len, input logic perr, input rx_frame_info_t info, input logic [31:0] exp,
                       input logic [31:0] mask, input logic exp_err, input int nstat, input int neof,
                       input int nwr);
        int s0, e0, w0;
        s0 = stat_n;
        e0 = eof_n;
        w0 = wq.size();
        err_q = 1'b0;
        send(len, perr, info);
        check_word("status strobes", 32'(s0 + nstat), 32'(stat_n));
        check_word("end marks", 32'(e0 + neof), 32'(eof_n));
        check_word("writes", 32'(w0 + nwr), 32'(wq.size()));
        check_flag("frame error", exp_err, err_q);
        if (nstat > 0)
            check_word("status word", exp & mask, stat_q & mask);
        for (int i = 0; i < nwr && w0 + i < wq.size(); i++)
            check_word("data", 32'(8'(8'h30 + i)), 32'(wq[w0 + i]));
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        run(6, 1'b0, '0, 32'h0080_0006, '1, 1'b0, 1, 1, 6);
        for (int k = 0; k < 12; k++)
            run(1, 1'b0, 12'(12'h800 >> k), (32'h1 << sbit[k]) | 32'h1 | (32'(!(k inside {7, 8, 10, 11})) << ST_RX_OK),
                '1, k inside {7, 8}, 1, 1, 1);
        run(2, 1'b1, '0, 32'h0000_0002, '1, 1'b1, 1, 1, 2);
        // Carrier and collision count only in half-duplex 10/100, classic or SGMII
        for (int c = 0; c < 4; c++)
        begin
            gbit_mode_i <= (c == 1);
            half_duplex_i <= (c != 2);
            mac_option_i <= (c == 1) ? OPT_GIGABIT : (c == 3) ? OPT_SGMII : OPT_CLASSIC;
            crs_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            crs_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            col_i <= 1'b1;
            run(3, 1'b0, '0, {4'h0, (c == 0 || c == 3), 3'h0, (c == 1 || c == 2), 23'h3}, '1,
                1'b0, 1, 1, 3);
            col_i <= 1'b0;
        end
        gbit_mode_i <= 1'b0;
        drop_req_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (int d = 0; d < 2; d++)
            run(3, 1'b0, '0, 32'h0400_0000, 32'h0480_0000, 1'b0, 1, 0, 0);
        drop_req_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        // A request raised mid-frame waits for the next frame start
        fork
            run(6, 1'b0, '0, 32'h0080_0006, '1, 1'b0, 1, 1, 6);
            begin
                repeat (3) @(posedge clk_i);
                drop_req_i <= 1'b1;
            end
        join
        run(1, 1'b0, '0, 32'h0400_0001, '1, 1'b0, 1, 0, 0);
        drop_req_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rx_enable_i <= 1'b0;
        run(2, 1'b0, '0, '0, '0, 1'b0, 0, 0, 0);
        rx_enable_i <= 1'b1;
        // Overflow: reader stalled until the flag is seen to stand
        drain_en <= 1'b0;
        // Full shows from the edge that fills the last free slot, where the next strobe is already registered, so one more byte is strobed
        run(8, 1'b0, '0, 32'h0000_0008, 32'h0080_FFFF, 1'b0, 1, 1, DEPTH + 1);
        check_flag("overflow set", 1'b1, rx_fifo_error_o);
        repeat (10) @(posedge clk_i);
        check_flag("overflow held", 1'b1, rx_fifo_error_o);
        drain_en <= 1'b1;
        for (int t = 0; t < 20 && rx_fifo_error_o !== 1'b0; t++)
            @(posedge clk_i);
        check_flag("overflow cleared", 1'b0, rx_fifo_error_o);
        run(3, 1'b0, '0, 32'h0080_0003, '1, 1'b0, 1, 1, 3);
        check_word("writes during overflow", 32'h0, 32'(wr_bad));
        conclude();
    end

    initial
    begin
        #2000000;
        mismatches++;
        conclude();
    end
endmodule
